// ---- verilog/vis_pkg.sv ----
// Shared constants and types for the video input select configuration block
package vis_pkg;

    // ------------------------------------------------------------------
    // Serial port and register map
    // ------------------------------------------------------------------
    localparam logic [6:0] VIS_DEV_ADDR_BASE = 7'h20;   // Write address 0x40, strap sets bit 0
    localparam logic [7:0] VIS_ADDR_FMT      = 8'h00;
    localparam logic [7:0] VIS_ADDR_MAP      = 8'h0e;
    localparam logic [7:0] VIS_ADDR_ACE      = 8'h80;
    localparam logic [7:0] VIS_RST_FMT       = 8'h00;
    localparam logic [7:0] VIS_RST_MAP       = 8'h00;
    localparam logic [7:0] VIS_RST_ACE       = 8'h00;
    localparam int         VIS_FMT_HI        = 4;
    localparam int         VIS_MAP_LO        = 5;
    localparam int         VIS_MAP_HI        = 6;
    localparam int         VIS_ACE_BIT       = 7;
    localparam logic [2:0] VIS_BIT_LAST      = 3'h7;
    localparam logic [1:0] VIS_MAP_USER      = 2'h0;
    localparam logic [1:0] VIS_MAP_INTR      = 2'h1;
    localparam logic [1:0] VIS_MAP_USER2     = 2'h2;

    // ------------------------------------------------------------------
    // Input format codes
    // ------------------------------------------------------------------
    localparam logic [4:0] VIS_FMT_CVBS_LAST  = 5'h07;
    localparam logic [4:0] VIS_FMT_CVBS_LAST4 = 5'h03;
    localparam logic [4:0] VIS_FMT_YC_FIRST   = 5'h08;
    localparam logic [4:0] VIS_FMT_YC_LAST    = 5'h0b;
    localparam logic [4:0] VIS_FMT_YC_LAST4   = 5'h09;
    localparam logic [4:0] VIS_FMT_COMP_A     = 5'h0c;
    localparam logic [4:0] VIS_FMT_COMP_B     = 5'h0d;
    localparam logic [2:0] VIS_COMP_B_BASE    = 3'h3;

    typedef enum logic [1:0] {
        VIS_MODE_OFF  = 2'b00,
        VIS_MODE_CVBS = 2'b01,
        VIS_MODE_YC   = 2'b10,
        VIS_MODE_COMP = 2'b11
    } vis_mode_t;

    typedef struct packed {
        vis_mode_t  mode;
        logic       valid;
        logic [7:0] chan_power;
        logic [2:0] y_chan;
        logic [2:0] c_chan;
        logic [2:0] r_chan;
    } vis_route_t;

    typedef enum logic [2:0] {
        VIS_ST_IDLE = 3'b000,
        VIS_ST_ADDR = 3'b001,
        VIS_ST_SUB  = 3'b010,
        VIS_ST_WR   = 3'b011,
        VIS_ST_ACK  = 3'b100,
        VIS_ST_RD   = 3'b101,
        VIS_ST_MACK = 3'b110
    } vis_state_t;

endpackage : vis_pkg

// ---- verilog/vis_config.sv ----
// Serial register port, sub map select and input routing decode
`timescale 1ns/1ps
module vis_config
    import vis_pkg::*;
#(
    parameter bit EIGHT_INPUT = 1'b1
)(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       addr_lsb_pin,
    output logic [4:0]      input_format_select,
    output logic [1:0]      sub_map_select,
    output logic            adaptive_contrast_boost,
    output vis_route_t      route
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;
    logic [1:0] lsb_sync_reg;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            lsb_sync_reg <= 2'h0;
        end
        else
        begin
            scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
            lsb_sync_reg <= {lsb_sync_reg[0], addr_lsb_pin};
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic sda_bit;
    logic start_det;
    logic stop_det;

    assign scl_rise  = scl_sync_reg[1] & ~scl_sync_reg[2];
    assign scl_fall  = ~scl_sync_reg[1] & scl_sync_reg[2];
    assign sda_bit   = sda_sync_reg[1];
    assign start_det = scl_sync_reg[1] & scl_sync_reg[2] & ~sda_sync_reg[1] & sda_sync_reg[2];
    assign stop_det  = scl_sync_reg[1] & scl_sync_reg[2] & sda_sync_reg[1] & ~sda_sync_reg[2];

    // ------------------------------------------------------------------
    // Register storage and map decode
    // ------------------------------------------------------------------
    logic [7:0] fmt_reg;
    logic [7:0] map_reg;
    logic [7:0] ace_reg;
    logic [1:0] map_sel;

    assign map_sel = map_reg[VIS_MAP_HI:VIS_MAP_LO];

    // Map select answers in every sub map so software can always get back
    function automatic logic addr_valid(input logic [1:0] m, input logic [7:0] a);
        addr_valid = (a == VIS_ADDR_MAP)
                   || (m == VIS_MAP_USER && a == VIS_ADDR_FMT)
                   || (m == VIS_MAP_USER2 && a == VIS_ADDR_ACE);
    endfunction : addr_valid

    function automatic logic [7:0] reg_read(input logic [1:0] m, input logic [7:0] a,
                                            input logic [7:0] f, input logic [7:0] s,
                                            input logic [7:0] e);
        reg_read = 8'h00;
        if (a == VIS_ADDR_MAP)
            reg_read = s;
        else if (m == VIS_MAP_USER && a == VIS_ADDR_FMT)
            reg_read = f;
        else if (m == VIS_MAP_USER2 && a == VIS_ADDR_ACE)
            reg_read = e;
    endfunction : reg_read

    // ------------------------------------------------------------------
    // Serial slave state machine
    // ------------------------------------------------------------------
    vis_state_t state_reg, state_next;
    vis_state_t after_reg, after_next;
    logic [2:0] cnt_reg, cnt_next;
    logic       done_reg, done_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] rd_reg, rd_next;
    logic [7:0] sub_reg, sub_next;
    logic       oe_reg, oe_next;
    logic       wr_en;
    logic [7:0] sub_inc;
    logic       addr_hit;

    assign sub_inc  = sub_reg + 8'h01;
    assign addr_hit = shift_reg[7:1] == {VIS_DEV_ADDR_BASE[6:1], lsb_sync_reg[1]};

    always_comb
    begin
        state_next = state_reg;
        after_next = after_reg;
        cnt_next   = cnt_reg;
        done_next  = done_reg;
        shift_next = shift_reg;
        rd_next    = rd_reg;
        sub_next   = sub_reg;
        oe_next    = oe_reg;
        wr_en      = 1'b0;
        if (start_det)
        begin
            state_next = VIS_ST_ADDR;
            cnt_next   = 3'h0;
            done_next  = 1'b0;
            oe_next    = 1'b0;
        end
        else if (stop_det)
        begin
            state_next = VIS_ST_IDLE;
            oe_next    = 1'b0;
        end
        else
        begin
            case (state_reg)
                VIS_ST_ADDR, VIS_ST_SUB, VIS_ST_WR:
                begin
                    if (scl_rise && !done_reg)
                    begin
                        shift_next = {shift_reg[6:0], sda_bit};
                        if (cnt_reg == VIS_BIT_LAST)
                            done_next = 1'b1;
                        else
                            cnt_next = cnt_reg + 3'h1;
                    end
                    else if (scl_fall && done_reg)
                    begin
                        done_next  = 1'b0;
                        cnt_next   = 3'h0;
                        state_next = VIS_ST_IDLE;   // Refused bytes fall back to idle
                        if (state_reg == VIS_ST_ADDR && addr_hit)
                        begin
                            oe_next    = 1'b1;
                            state_next = VIS_ST_ACK;
                            after_next = shift_reg[0] ? VIS_ST_RD : VIS_ST_SUB;
                            rd_next    = reg_read(map_sel, sub_reg, fmt_reg, map_reg, ace_reg);
                        end
                        else if (state_reg == VIS_ST_SUB && addr_valid(map_sel, shift_reg))
                        begin
                            sub_next   = shift_reg;
                            oe_next    = 1'b1;
                            state_next = VIS_ST_ACK;
                            after_next = VIS_ST_WR;
                        end
                        else if (state_reg == VIS_ST_WR && addr_valid(map_sel, sub_reg))
                        begin
                            wr_en      = 1'b1;
                            sub_next   = sub_inc;
                            oe_next    = 1'b1;
                            state_next = VIS_ST_ACK;
                            after_next = VIS_ST_WR;
                        end
                    end
                end
                VIS_ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        state_next = after_reg;
                        cnt_next   = 3'h0;
                        if (after_reg == VIS_ST_RD)
                        begin
                            oe_next = ~rd_reg[7];
                            rd_next = {rd_reg[6:0], 1'b0};
                        end
                        else
                            oe_next = 1'b0;
                    end
                end
                VIS_ST_RD:
                begin
                    if (scl_rise)
                    begin
                        if (cnt_reg == VIS_BIT_LAST)
                            state_next = VIS_ST_MACK;
                        else
                            cnt_next = cnt_reg + 3'h1;
                    end
                    else if (scl_fall)
                    begin
                        oe_next = ~rd_reg[7];
                        rd_next = {rd_reg[6:0], 1'b0};
                    end
                end
                VIS_ST_MACK:
                begin
                    if (scl_fall)
                        oe_next = 1'b0;
                    else if (scl_rise)
                    begin
                        if (!sda_bit)
                        begin
                            sub_next   = sub_inc;
                            rd_next    = reg_read(map_sel, sub_inc, fmt_reg, map_reg, ace_reg);
                            state_next = VIS_ST_ACK;
                            after_next = VIS_ST_RD;
                        end
                        else
                            state_next = VIS_ST_IDLE;
                    end
                end
                default:
                begin
                    state_next = VIS_ST_IDLE;
                    oe_next    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= VIS_ST_IDLE;
            after_reg <= VIS_ST_IDLE;
            cnt_reg   <= 3'h0;
            done_reg  <= 1'b0;
            shift_reg <= 8'h00;
            rd_reg    <= 8'h00;
            sub_reg   <= 8'h00;
            oe_reg    <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            after_reg <= after_next;
            cnt_reg   <= cnt_next;
            done_reg  <= done_next;
            shift_reg <= shift_next;
            rd_reg    <= rd_next;
            sub_reg   <= sub_next;
            oe_reg    <= oe_next;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic [7:0] fmt_next;
    logic [7:0] map_next;
    logic [7:0] ace_next;

    always_comb
    begin
        fmt_next = fmt_reg;
        map_next = map_reg;
        ace_next = ace_reg;
        if (wr_en)
        begin
            if (sub_reg == VIS_ADDR_MAP)
                map_next = shift_reg;
            else if (map_sel == VIS_MAP_USER && sub_reg == VIS_ADDR_FMT)
                fmt_next = shift_reg;
            else if (map_sel == VIS_MAP_USER2 && sub_reg == VIS_ADDR_ACE)
                ace_next = shift_reg;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            fmt_reg <= VIS_RST_FMT;
            map_reg <= VIS_RST_MAP;
            ace_reg <= VIS_RST_ACE;
        end
        else
        begin
            fmt_reg <= fmt_next;
            map_reg <= map_next;
            ace_reg <= ace_next;
        end
    end

    // ------------------------------------------------------------------
    // Input routing decode
    // ------------------------------------------------------------------
    // Reserved codes power every channel down rather than guess a routing
    function automatic vis_route_t route_decode(input logic [4:0] c);
        logic [2:0] base;
        route_decode = '0;
        base         = c[0] ? VIS_COMP_B_BASE : 3'h0;
        if (c <= VIS_FMT_CVBS_LAST && (EIGHT_INPUT || c <= VIS_FMT_CVBS_LAST4))
        begin
            route_decode.mode       = VIS_MODE_CVBS;
            route_decode.valid      = 1'b1;
            route_decode.y_chan     = c[2:0];
            route_decode.chan_power = 8'h01 << c[2:0];
        end
        else if (c >= VIS_FMT_YC_FIRST && c <= VIS_FMT_YC_LAST
                 && (EIGHT_INPUT || c <= VIS_FMT_YC_LAST4))
        begin
            route_decode.mode       = VIS_MODE_YC;
            route_decode.valid      = 1'b1;
            route_decode.y_chan     = {c[1:0], 1'b0};
            route_decode.c_chan     = {c[1:0], 1'b1};
            route_decode.chan_power = 8'h03 << {c[1:0], 1'b0};
        end
        else if (c == VIS_FMT_COMP_A || (c == VIS_FMT_COMP_B && EIGHT_INPUT))
        begin
            route_decode.mode       = VIS_MODE_COMP;
            route_decode.valid      = 1'b1;
            route_decode.y_chan     = base;
            route_decode.c_chan     = base + 3'h1;
            route_decode.r_chan     = base + 3'h2;
            route_decode.chan_power = 8'h07 << base;
        end
    endfunction : route_decode

    vis_route_t route_reg, route_next;

    always_comb
    begin
        route_next = route_decode(fmt_reg[VIS_FMT_HI:0]);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            route_reg <= '0;
        else
            route_reg <= route_next;
    end

    assign route                   = route_reg;
    assign input_format_select     = fmt_reg[VIS_FMT_HI:0];
    assign sub_map_select          = map_reg[VIS_MAP_HI:VIS_MAP_LO];
    assign adaptive_contrast_boost = ace_reg[VIS_ACE_BIT];
    assign sda_oe                  = oe_reg;
    assign sda_out                 = 1'b0;   // Open drain: only ever pulls low

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_byte_done;
        done_reg && scl_fall && !start_det && !stop_det;
    endsequence

    ace_reset_off_a: assert property (@(posedge clk) $fell(rst) |->
                                      !adaptive_contrast_boost && !sda_oe)
        else $error("contrast boost on after reset");
    cvbs_power_a: assert property (route.mode == VIS_MODE_CVBS |-> $onehot(route.chan_power))
        else $error("composite mode powers wrong channels");
    // Route lags the format register by exactly one cycle
    cvbs_chan_a: assert property (fmt_reg[4:0] <= VIS_FMT_CVBS_LAST4 |=>
                                  route.y_chan == $past(fmt_reg[2:0]))
        else $error("composite channel mismatch");
    yc_pair_a: assert property (fmt_reg[4:2] == 3'h2 && (EIGHT_INPUT || !fmt_reg[1]) |=>
                                route.c_chan == {$past(fmt_reg[1:0]), 1'b1})
        else $error("luma chroma pair mismatch");
    comp_map_a: assert property (fmt_reg[4:0] == VIS_FMT_COMP_A |=>
                                 route.mode == VIS_MODE_COMP && route.r_chan == 3'h2)
        else $error("component routing wrong");
    reserved_a: assert property (fmt_reg[4:0] > VIS_FMT_COMP_B |=>
                                 !route.valid && route.chan_power == 8'h00)
        else $error("reserved code gave routing");
    mode_match_a: assert property (route.valid |-> route.mode != VIS_MODE_OFF)
        else $error("valid routing without core mode");
    map_write_a: assert property (wr_en && sub_reg == VIS_ADDR_MAP |=>
                                  sub_map_select == $past(shift_reg[6:5]))
        else $error("sub map select not updated");
    ace_write_a: assert property (wr_en && map_sel == VIS_MAP_USER2
                                  && sub_reg == VIS_ADDR_ACE
                                  |=> adaptive_contrast_boost == $past(shift_reg[7]))
        else $error("contrast boost not written");
    hold_cfg_a: assert property (!wr_en |=> $stable(fmt_reg) && $stable(ace_reg))
        else $error("configuration changed without write");
    addr_ack_a: assert property (state_reg == VIS_ST_ADDR ##0 s_byte_done ##0 addr_hit
                                 |=> sda_oe && state_reg == VIS_ST_ACK)
        else $error("own address not acknowledged");
    addr_miss_a: assert property (state_reg == VIS_ST_ADDR ##0 s_byte_done ##0 !addr_hit
                                  |=> !sda_oe && state_reg == VIS_ST_IDLE)
        else $error("foreign address acknowledged");

endmodule : vis_config

// ---- bench/vis_i2c_master.sv ----
// Serial bus controller model that writes and reads the configuration port
`timescale 1ns/1ps
module vis_i2c_master
(
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl = 1'b1,
    output logic      sda_drv = 1'b1
);
    // ------------------------------------------------------------------
    // Bus phases
    // ------------------------------------------------------------------
    // Each phase is 8 cycles, well beyond the 3 cycles the port synchronisers need
    localparam int HALF = 8;

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : hold

    // Also serves as repeated start, since SCL is low on entry then
    task automatic start_cond();
        sda_drv = 1'b1;
        hold(HALF);
        scl = 1'b1;
        hold(HALF);
        sda_drv = 1'b0;
        hold(HALF);
        scl = 1'b0;
        hold(HALF);
    endtask : start_cond

    task automatic stop_cond();
        sda_drv = 1'b0;
        hold(HALF);
        scl = 1'b1;
        hold(HALF);
        sda_drv = 1'b1;
        hold(HALF);
    endtask : stop_cond

    // Data moves only well inside the low phase, so no false start or stop
    task automatic bit_io(input logic b, output logic r);
        sda_drv = b;
        hold(HALF);
        scl = 1'b1;
        hold(HALF);
        r = sda_line;
        scl = 1'b0;
        hold(HALF);
    endtask : bit_io

    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask : write_byte

    task automatic read_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(last, r);
    endtask : read_byte
endmodule : vis_i2c_master

// ---- bench/testbench.sv ----
// Self-checking bench for the video input select configuration block
`timescale 1ns/1ps
module testbench
    import vis_pkg::*;
;
    typedef struct packed {
        logic [4:0] code;
        vis_mode_t  mode;
        logic [7:0] mask;
        logic [2:0] y;
        logic [2:0] c;
        logic [2:0] r;
    } vis_row_t;

    localparam int LIMIT = 60000;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       lsb = 1'b0;
    logic       scl, sda_drv, sda_line, sda_out, sda_oe, sda_out4, sda_oe4;
    logic [4:0] fmt;
    logic [1:0] map;
    logic       ace;
    vis_route_t route, route4;
    logic [2:0] acks;
    logic [7:0] rdata;
    int         fail_count = 0;
    int         check_count = 0;
    int         cyc = 0;
    vis_row_t   rows [16];
    logic [4:0] codes4 [5] = '{5'h03, 5'h04, 5'h09, 5'h0a, 5'h0d};
    logic       valid4 [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

    always #4 clk = ~clk;
    // Open-drain line with pull-up
    assign sda_line = sda_drv & (~sda_oe | sda_out) & (~sda_oe4 | sda_out4);

    vis_i2c_master vis_i2c_master_inst (.clk(clk), .sda_line(sda_line), .scl(scl),
        .sda_drv(sda_drv));
    vis_config #(.EIGHT_INPUT(1'b1)) vis_config_inst (.clk(clk), .rst(rst), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .addr_lsb_pin(lsb),
        .input_format_select(fmt), .sub_map_select(map), .adaptive_contrast_boost(ace),
        .route(route));
    // Four-input variant strapped to the other address
    vis_config #(.EIGHT_INPUT(1'b0)) vis_config_four_inst (.clk(clk), .rst(rst), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out4), .sda_oe(sda_oe4), .addr_lsb_pin(~lsb),
        .input_format_select(), .sub_map_select(), .adaptive_contrast_boost(),
        .route(route4));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t %s: got %0h exp %0h", $time, msg, got, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim

    function automatic logic [6:0] dev(input logic b);
        return {VIS_DEV_ADDR_BASE[6:1], b};
    endfunction : dev

    task automatic wr(input logic [6:0] a, input logic [7:0] sub, input logic [7:0] d);
        vis_i2c_master_inst.start_cond();
        vis_i2c_master_inst.write_byte({a, 1'b0}, acks[2]);
        vis_i2c_master_inst.write_byte(sub, acks[1]);
        vis_i2c_master_inst.write_byte(d, acks[0]);
        vis_i2c_master_inst.stop_cond();
    endtask : wr

    task automatic rd(input logic [7:0] sub);
        logic a;
        vis_i2c_master_inst.start_cond();
        vis_i2c_master_inst.write_byte({dev(lsb), 1'b0}, a);
        vis_i2c_master_inst.write_byte(sub, a);
        vis_i2c_master_inst.start_cond();
        vis_i2c_master_inst.write_byte({dev(lsb), 1'b1}, a);
        vis_i2c_master_inst.read_byte(1'b1, rdata);
        vis_i2c_master_inst.stop_cond();
    endtask : rd

    task automatic do_reset();
        rst = 1'b1;
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask : do_reset

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == LIMIT)
        begin
            fail_count++;
            $display("[ERR] %0t timeout", $time);
            end_sim();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        for (int i = 0; i < 8; i++)
            rows[i] = '{5'(i), VIS_MODE_CVBS, 8'h01 << i, 3'(i), 3'h0, 3'h0};
        rows[8]  = '{5'h08, VIS_MODE_YC, 8'h03, 3'h0, 3'h1, 3'h0};
        rows[9]  = '{5'h09, VIS_MODE_YC, 8'h0c, 3'h2, 3'h3, 3'h0};
        rows[10] = '{5'h0a, VIS_MODE_YC, 8'h30, 3'h4, 3'h5, 3'h0};
        rows[11] = '{5'h0b, VIS_MODE_YC, 8'hc0, 3'h6, 3'h7, 3'h0};
        rows[12] = '{5'h0c, VIS_MODE_COMP, 8'h07, 3'h0, 3'h1, 3'h2};
        rows[13] = '{5'h0d, VIS_MODE_COMP, 8'h38, 3'h3, 3'h4, 3'h5};
        rows[14] = '{5'h0e, VIS_MODE_OFF, 8'h00, 3'h0, 3'h0, 3'h0};
        rows[15] = '{5'h1f, VIS_MODE_OFF, 8'h00, 3'h0, 3'h0, 3'h0};
        do_reset();
        check(ace, 1'b0, "boost after reset");
        check(map, VIS_MAP_USER, "map after reset");
        check(route.mode, VIS_MODE_CVBS, "mode after reset");
        foreach (rows[i])
        begin
            // Upper bits set so the field boundary is exercised
            wr(dev(lsb), VIS_ADDR_FMT, {3'h5, rows[i].code});
            check(acks, 3'h7, "format write ack");
            check(fmt, rows[i].code, "format field");
            check(route.mode, rows[i].mode, "core mode");
            check(route.valid, rows[i].mode != VIS_MODE_OFF, "route valid");
            if (rows[i].mode inside {VIS_MODE_CVBS, VIS_MODE_OFF})
                check(route.chan_power, rows[i].mask, "power map");
            else
                check(route.chan_power & rows[i].mask, rows[i].mask, "inputs on");
            if (rows[i].mode != VIS_MODE_OFF)
                check(route.y_chan, rows[i].y, "luma input");
            if (rows[i].mode inside {VIS_MODE_YC, VIS_MODE_COMP})
                check(route.c_chan, rows[i].c, "chroma input");
            if (rows[i].mode == VIS_MODE_COMP)
                check(route.r_chan, rows[i].r, "red input");
        end
        rd(VIS_ADDR_FMT);
        check(rdata, 8'hbf, "format readback");
        wr(dev(lsb), VIS_ADDR_FMT, 8'h02);
        wr(dev(lsb), VIS_ADDR_ACE, 8'h80);
        check(acks, 3'h4, "boost hidden in user map");
        check(ace, 1'b0, "boost still off");
        wr(dev(lsb), VIS_ADDR_MAP, 8'h20);
        check(map, VIS_MAP_INTR, "interrupt map");
        wr(dev(lsb), VIS_ADDR_FMT, 8'h09);
        check({acks, fmt}, {3'h4, 5'h02}, "format hidden in interrupt map");
        wr(dev(lsb), VIS_ADDR_MAP, 8'h40);
        check(map, VIS_MAP_USER2, "second map");
        wr(dev(lsb), VIS_ADDR_ACE, 8'h80);
        check(ace, 1'b1, "boost on");
        wr(dev(lsb), VIS_ADDR_FMT, 8'h05);
        check(acks, 3'h4, "format hidden in second map");
        wr(dev(lsb), VIS_ADDR_MAP, 8'h00);
        check(map, VIS_MAP_USER, "user map back");
        check({ace, fmt}, 6'h22, "values kept");
        wr(dev(lsb), VIS_ADDR_MAP, 8'h40);
        wr(dev(lsb), VIS_ADDR_ACE, 8'h00);
        check(ace, 1'b0, "boost off");
        rd(VIS_ADDR_MAP);
        check(rdata, 8'h40, "map readback");
        wr(dev(lsb), VIS_ADDR_MAP, 8'h00);
        lsb = 1'b1;
        wr(dev(1'b1), VIS_ADDR_FMT, 8'h06);
        check({acks, fmt}, {3'h7, 5'h06}, "alternate address");
        wr(7'h23, VIS_ADDR_FMT, 8'h01);
        check({acks, fmt}, {3'h0, 5'h06}, "foreign address ignored");
        for (int i = 0; i < 5; i++)
        begin
            wr(dev(1'b0), VIS_ADDR_FMT, {3'h0, codes4[i]});
            check(route4.valid, valid4[i], "four-input routing");
            check(fmt, 5'h06, "other device untouched");
        end
        wr(dev(1'b1), VIS_ADDR_MAP, 8'h40);
        wr(dev(1'b1), VIS_ADDR_ACE, 8'h80);
        do_reset();
        check({fmt, map, ace}, 8'h00, "state after second reset");
        check(route.chan_power, 8'h01, "input 1 after reset");
        end_sim();
    end
endmodule : testbench
